// [core/dtc_cfg_if.sv]
// per-trigger configuration carried from register file to matcher
`timescale 1ns/10ps
`default_nettype none
interface dtc_cfg_if;
  dtc_pkg::dtc_word_t cfg;
  dtc_pkg::dtc_word_t cmp;
  modport src (output cfg, output cmp);
  modport dst (input cfg, input cmp);
endinterface
`default_nettype wire

// [core/dtc_defines.svh]
// register addresses, field positions and fixed values of the trigger unit
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_ADDR_TRIG_SEL 12'h7a0
`define DTC_ADDR_TRIG_CFG 12'h7a1
`define DTC_ADDR_TRIG_CMP 12'h7a2
`define DTC_ADDR_TRIG_AUX 12'h7a3
`define DTC_ADDR_TRIG_INFO 12'h7a4
`define DTC_ADDR_TRIG_CTRL 12'h7a5
`define DTC_SEL_RESET 32'h0000_0000
`define DTC_CFG_RESET 32'h2800_1000
`define DTC_CFG_DISABLED 32'hf800_0000
`define DTC_CMP_RESET 32'h0000_0000
`define DTC_INFO_VALUE 32'h0000_8064
`define DTC_EXC_CODE_MASK 32'h0300_09ae
`define DTC_TYPE_HI 31
`define DTC_TYPE_LO 28
`define DTC_DEBUG_ONLY_BIT 27
`define DTC_MATCH_HI 10
`define DTC_MATCH_LO 7
`define DTC_AM_M_BIT 6
`define DTC_AM_U_BIT 3
`define DTC_AM_EXEC_BIT 2
`define DTC_AM_STORE_BIT 1
`define DTC_AM_LOAD_BIT 0
`define DTC_ET_M_BIT 9
`define DTC_ET_U_BIT 6
`define DTC_AM_ACTION 4'h1
`define DTC_ET_ACTION 6'h01
`define DTC_MATCH_EQ 4'h0
`define DTC_MATCH_GE 4'h2
`define DTC_MATCH_LT 4'h3
`endif

// [core/dtc_legalize.sv]
// legalizes a written configuration word according to its type code
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"
module dtc_legalize (
  input wire logic [31:0] wdata_i,
  output logic [31:0] legal_o
);
  logic [3:0] ty;
  logic [3:0] mt;

  // unknown types collapse to the one disabled encoding
  always_comb begin
    ty = wdata_i[`DTC_TYPE_HI:`DTC_TYPE_LO];
    mt = wdata_i[`DTC_MATCH_HI:`DTC_MATCH_LO];
    if (mt != `DTC_MATCH_GE && mt != `DTC_MATCH_LT) begin
      mt = `DTC_MATCH_EQ;
    end
    legal_o = `DTC_CFG_DISABLED;
    if (wdata_i != 32'h0000_0000) begin
      case (ty)
        4'h2, 4'h6: begin
          // mask, hit, select, timing, size, chain all zero
          legal_o = {ty, 1'b1, 11'h000, `DTC_AM_ACTION, 1'b0, mt,
            wdata_i[`DTC_AM_M_BIT], 2'b00, wdata_i[`DTC_AM_U_BIT],
            wdata_i[`DTC_AM_EXEC_BIT:`DTC_AM_LOAD_BIT]};
        end
        4'h5: begin
          legal_o = {ty, 1'b1, 17'h0_0000, wdata_i[`DTC_ET_M_BIT], 2'b00,
            wdata_i[`DTC_ET_U_BIT], `DTC_ET_ACTION};
        end
        default: legal_o = `DTC_CFG_DISABLED;
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/dtc_match.sv]
// one trigger's comparators: address match and exception match
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"
module dtc_match (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  dtc_cfg_if.dst cfg_if,
  input wire logic priv_m_i,
  input wire logic fetch_valid_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic load_valid_i,
  input wire logic [31:0] load_addr_i,
  input wire logic store_valid_i,
  input wire logic [31:0] store_addr_i,
  input wire logic exc_valid_i,
  input wire logic [4:0] exc_code_i,
  output logic hit_o
);
  logic [3:0] ty;
  logic [3:0] mt;
  logic is_addr;
  logic am_en;
  logic et_en;
  logic ok_f;
  logic ok_l;
  logic ok_s;

  function automatic logic cmp_ok(input logic [3:0] m,
                                  input logic [31:0] a,
                                  input logic [31:0] v);
    case (m)
      `DTC_MATCH_EQ: cmp_ok = (a == v);
      `DTC_MATCH_GE: cmp_ok = (a >= v);
      `DTC_MATCH_LT: cmp_ok = (a < v);
      default: cmp_ok = 1'b0;
    endcase
  endfunction

  // privilege gating masks the compare results, so a disabled trigger never hits
  always_comb begin
    ty = cfg_if.cfg[`DTC_TYPE_HI:`DTC_TYPE_LO];
    mt = cfg_if.cfg[`DTC_MATCH_HI:`DTC_MATCH_LO];
    is_addr = (ty == dtc_pkg::DTC_TY_ADDR) || (ty == dtc_pkg::DTC_TY_ADDR6);
    am_en = is_addr && (priv_m_i ? cfg_if.cfg[`DTC_AM_M_BIT]
                                 : cfg_if.cfg[`DTC_AM_U_BIT]);
    et_en = (ty == dtc_pkg::DTC_TY_EXC) &&
            (priv_m_i ? cfg_if.cfg[`DTC_ET_M_BIT]
                      : cfg_if.cfg[`DTC_ET_U_BIT]);
    ok_f = fetch_valid_i && cfg_if.cfg[`DTC_AM_EXEC_BIT] &&
           cmp_ok(mt, fetch_addr_i, cfg_if.cmp);
    ok_s = store_valid_i && cfg_if.cfg[`DTC_AM_STORE_BIT] &&
           cmp_ok(mt, store_addr_i, cfg_if.cmp);
    ok_l = load_valid_i && cfg_if.cfg[`DTC_AM_LOAD_BIT] &&
           cmp_ok(mt, load_addr_i, cfg_if.cmp);
    hit_o = (am_en && (ok_f || ok_s || ok_l)) ||
            (et_en && exc_valid_i && cfg_if.cmp[exc_code_i]);
  end

  a_hit_gated: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    hit_o |-> (ty != dtc_pkg::DTC_TY_OFF) && (am_en || et_en))
    else $error("trigger hit while disabled or privilege off");
  a_exc_fire: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (et_en && exc_valid_i && cfg_if.cmp[exc_code_i]) |-> hit_o)
    else $error("enabled exception code did not fire");
endmodule
`default_nettype wire

// [core/dtc_pkg.sv]
// types shared by the debug trigger unit
package dtc_pkg;
  typedef enum logic [3:0] {
    DTC_TY_ADDR = 4'h2,
    DTC_TY_EXC = 4'h5,
    DTC_TY_ADDR6 = 4'h6,
    DTC_TY_OFF = 4'hf
  } dtc_type_e;
  typedef logic [31:0] dtc_word_t;
endpackage

// [core/dtc_trigger_unit.sv]
// debug trigger unit: select, configuration and compare registers, matchers
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"
module dtc_trigger_unit #(
  parameter int TRIGGER_COUNT_PARAM = 1
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] csr_addr_i,
  input wire logic csr_re_i,
  input wire logic csr_we_i,
  input wire logic [31:0] csr_wdata_i,
  input wire logic debug_mode_i,
  input wire logic priv_m_i,
  input wire logic fetch_valid_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic load_valid_i,
  input wire logic [31:0] load_addr_i,
  input wire logic store_valid_i,
  input wire logic [31:0] store_addr_i,
  input wire logic exc_valid_i,
  input wire logic [4:0] exc_code_i,
  output logic [31:0] csr_rdata_o,
  output logic dbg_req_o,
  output logic [TRIGGER_COUNT_PARAM-1:0] trig_hit_o
);
  localparam int SEL_W = (TRIGGER_COUNT_PARAM > 1) ?
                         $clog2(TRIGGER_COUNT_PARAM) : 1;

  logic [SEL_W-1:0] sel_reg;
  logic [SEL_W-1:0] sel_next;
  logic [31:0] cfg_reg [TRIGGER_COUNT_PARAM];
  logic [31:0] cmp_reg [TRIGGER_COUNT_PARAM];
  logic [TRIGGER_COUNT_PARAM-1:0] hit;
  logic [TRIGGER_COUNT_PARAM-1:0] hit_reg;
  logic [TRIGGER_COUNT_PARAM-1:0] hit_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req_reg;
  logic req_next;
  logic [31:0] cfg_legal;
  logic wr_sel;
  logic wr_cfg;
  logic wr_cmp;
  logic [31:0] sel_cfg;
  logic [31:0] sel_cmp;

  // write strobes; data registers only move in debug mode
  always_comb begin
    wr_sel = csr_we_i && (csr_addr_i == `DTC_ADDR_TRIG_SEL);
    wr_cfg = csr_we_i && debug_mode_i &&
             (csr_addr_i == `DTC_ADDR_TRIG_CFG);
    wr_cmp = csr_we_i && debug_mode_i &&
             (csr_addr_i == `DTC_ADDR_TRIG_CMP);
    sel_cfg = cfg_reg[sel_reg];
    sel_cmp = cmp_reg[sel_reg];
  end

  // one legalizer shared by all triggers: only the selected one is written
  dtc_legalize u_legal (
    .wdata_i(csr_wdata_i),
    .legal_o(cfg_legal)
  );

  // select register keeps its value on an out-of-range write
  always_comb begin
    sel_next = sel_reg;
    if (wr_sel && (csr_wdata_i < 32'(TRIGGER_COUNT_PARAM))) begin
      sel_next = csr_wdata_i[SEL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < TRIGGER_COUNT_PARAM; gi++) begin : g_trig
      logic [31:0] cfg_next;
      logic [31:0] cmp_next;
      logic mine;

      dtc_cfg_if cfg_bus ();

      // per-trigger storage; the compare value is masked for exception type
      always_comb begin
        mine = (sel_reg == SEL_W'(gi));
        cfg_next = cfg_reg[gi];
        cmp_next = cmp_reg[gi];
        if (wr_cfg && mine) begin
          cfg_next = cfg_legal;
        end
        if (wr_cmp && mine) begin
          if (cfg_reg[gi][`DTC_TYPE_HI:`DTC_TYPE_LO] == dtc_pkg::DTC_TY_EXC)
          begin
            cmp_next = csr_wdata_i & `DTC_EXC_CODE_MASK;
          end else begin
            cmp_next = csr_wdata_i;
          end
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cfg_reg[gi] <= `DTC_CFG_RESET;
          cmp_reg[gi] <= `DTC_CMP_RESET;
        end else begin
          cfg_reg[gi] <= cfg_next;
          cmp_reg[gi] <= cmp_next;
        end
      end

      assign cfg_bus.cfg = cfg_reg[gi];
      assign cfg_bus.cmp = cmp_reg[gi];

      dtc_match u_match (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .cfg_if(cfg_bus.dst),
        .priv_m_i(priv_m_i),
        .fetch_valid_i(fetch_valid_i),
        .fetch_addr_i(fetch_addr_i),
        .load_valid_i(load_valid_i),
        .load_addr_i(load_addr_i),
        .store_valid_i(store_valid_i),
        .store_addr_i(store_addr_i),
        .exc_valid_i(exc_valid_i),
        .exc_code_i(exc_code_i),
        .hit_o(hit[gi])
      );

      // a disabled trigger stays silent whatever the pipeline shows
      a_off_silent: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        cfg_reg[gi][31:28] == 4'hf |-> !hit[gi])
        else $error("disabled trigger raised a hit");
    end
  endgenerate

  // read mux; unmapped, aux and ctrl registers answer zero, info answers its fixed value
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (csr_re_i) begin
      case (csr_addr_i)
        `DTC_ADDR_TRIG_SEL: rdata_next = 32'(sel_reg);
        `DTC_ADDR_TRIG_CFG: rdata_next = sel_cfg;
        `DTC_ADDR_TRIG_CMP: rdata_next = sel_cmp;
        `DTC_ADDR_TRIG_INFO: rdata_next = `DTC_INFO_VALUE;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // debug entry request; no new request while already halted
  always_comb begin
    hit_next = debug_mode_i ? '0 : hit;
    req_next = |hit_next;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
      hit_reg <= '0;
      req_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      req_reg <= req_next;
    end
  end

  assign csr_rdata_o = rdata_reg;
  assign trig_hit_o = hit_reg;
  assign dbg_req_o = req_reg;

  // select register: only implemented triggers can be picked
  a_sel_range: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    32'(sel_reg) < 32'(TRIGGER_COUNT_PARAM))
    else $error("trigger select out of range");
  a_sel_keep: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_sel && csr_wdata_i >= 32'(TRIGGER_COUNT_PARAM)) |=>
    $stable(sel_reg))
    else $error("illegal select value retained");
  a_sel_write: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_sel && csr_wdata_i < 32'(TRIGGER_COUNT_PARAM)) |=>
    32'(sel_reg) == $past(csr_wdata_i))
    else $error("legal select value not taken");

  // stored configuration is always one of the legal encodings
  a_type_legal: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] inside {4'h2, 4'h5, 4'h6, 4'hf})
    else $error("illegal trigger type stored");
  a_debug_bit: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[`DTC_DEBUG_ONLY_BIT])
    else $error("debug-only bit not set");
  a_write_guard: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (csr_we_i && !debug_mode_i && !wr_sel) |=>
    $stable(sel_cfg) && $stable(sel_cmp))
    else $error("trigger data written outside debug mode");
  a_zero_disable: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_cfg && csr_wdata_i == 32'h0000_0000) |=>
    sel_cfg == `DTC_CFG_DISABLED)
    else $error("zero write did not disable trigger");
  a_off_clean: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'hf |-> sel_cfg == `DTC_CFG_DISABLED)
    else $error("disabled trigger holds stray bits");
  a_cfg_write: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    wr_cfg |=> sel_cfg == $past(cfg_legal))
    else $error("configuration write not legalized");
  a_am_fixed: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h2 |-> sel_cfg[26:20] == 7'h00 &&
    !sel_cfg[11] && sel_cfg[5:4] == 2'b00)
    else $error("fixed address-match bits not zero");
  a_am_timing: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h2 |-> sel_cfg[19:18] == 2'b00)
    else $error("select or timing bit set");
  a_am_size: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h2 |-> sel_cfg[17:16] == 2'b00)
    else $error("access size not zero");
  a_am_action: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h2 |-> sel_cfg[15:12] == 4'h1)
    else $error("address-match action not one");
  a_match_code: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_cfg && csr_wdata_i[31:28] == 4'h2 &&
     csr_wdata_i[10:7] == 4'h1) |=> sel_cfg[10:7] == 4'h0)
    else $error("illegal match code not legalized");
  a_match_legal: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h2 |-> sel_cfg[10:7] inside {4'h0, 4'h2, 4'h3})
    else $error("stored match code not supported");
  // newer address-match type keeps the same low layout as the legacy one
  a_am6_fixed: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h6 |-> sel_cfg[26:16] == 11'h000 &&
    sel_cfg[15:12] == 4'h1 && !sel_cfg[11] && sel_cfg[5:4] == 2'b00)
    else $error("fixed newer address-match bits wrong");
  a_et_fixed: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sel_cfg[31:28] == 4'h5 |-> sel_cfg[26:10] == 17'h0_0000 &&
    sel_cfg[8:7] == 2'b00 && sel_cfg[5:0] == 6'h01)
    else $error("exception view fixed bits wrong");

  // compare value: masked for exception type, whole otherwise
  a_cmp_mask: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_cmp && sel_cfg[31:28] == 4'h5) |=>
    (sel_cmp & ~`DTC_EXC_CODE_MASK) == 32'h0000_0000)
    else $error("unsupported exception code bit stored");
  a_cmp_write: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_cmp && sel_cfg[31:28] != 4'h5) |=>
    sel_cmp == $past(csr_wdata_i))
    else $error("compare address not stored whole");

  // read path: data stands one cycle after the strobe, then clears
  a_rd_sel: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (csr_re_i && csr_addr_i == `DTC_ADDR_TRIG_SEL) |=>
    csr_rdata_o == 32'($past(sel_reg)))
    else $error("select read back wrong");
  a_rd_cfg: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (csr_re_i && csr_addr_i == `DTC_ADDR_TRIG_CFG) |=>
    csr_rdata_o == $past(sel_cfg))
    else $error("configuration read back wrong");
  a_rd_cmp: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (csr_re_i && csr_addr_i == `DTC_ADDR_TRIG_CMP) |=>
    csr_rdata_o == $past(sel_cmp))
    else $error("compare value read back wrong");
  a_rd_idle: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !csr_re_i |=> csr_rdata_o == 32'h0000_0000)
    else $error("read data left standing");

  // request path: one registered pulse per matching cycle outside debug mode
  a_req_quiet: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $past(debug_mode_i) |-> !dbg_req_o)
    else $error("debug request raised while in debug mode");
  a_req_hit: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!debug_mode_i && |hit) |=> dbg_req_o)
    else $error("match did not request debug entry");
  a_req_only: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    dbg_req_o == |trig_hit_o)
    else $error("request and per-trigger hits disagree");
endmodule
`default_nettype wire

// [sim/dtc_dbg_model.sv]
// debug mode controller model facing the trigger unit
`timescale 1ns/10ps
`default_nettype none
module dtc_dbg_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic dbg_req_i,
  input wire logic halt_i,
  input wire logic resume_i,
  output logic debug_mode_o
);
  logic pend_reg;
  // request seen on the rising edge; a request wins over a resume
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      pend_reg <= 1'b0;
    else if (dbg_req_i || halt_i)
      pend_reg <= 1'b1;
    else if (resume_i)
      pend_reg <= 1'b0;
  end
  // mode moves on the falling edge, clear of the unit's sampling edge
  always @(negedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      debug_mode_o <= 1'b0;
    else
      debug_mode_o <= pend_reg;
  end
endmodule
`default_nettype wire

// [sim/dtc_trigger_unit_bench.sv]
// self-checking bench for the debug trigger unit
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.svh"
module dtc_trigger_unit_bench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic re = 1'b0;
  logic we = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic priv_m = 1'b1;
  logic fv = 1'b0;
  logic lv = 1'b0;
  logic sv = 1'b0;
  logic ev = 1'b0;
  logic [31:0] acc_addr = 32'h0000_0000;
  logic halt = 1'b0;
  logic resume = 1'b0;
  logic debug_mode;
  logic [31:0] rdata;
  logic dbg_req;
  logic [1:0] hit;
  int n_errors = 0;
  int comparisons = 0;
  // writes, then the value each must read back
  localparam logic [31:0] LEG_WR [10] = '{32'h0000_0000, 32'hffff_ffff,
    32'h3000_0000, 32'h7000_0000, 32'h2fff_ffff, 32'h2000_0100,
    32'h2000_0180, 32'h2000_0080, 32'h5fff_ffff, 32'h6fff_ffff};
  localparam logic [31:0] LEG_RD [10] = '{32'hf800_0000, 32'hf800_0000,
    32'hf800_0000, 32'hf800_0000, 32'h2800_104f, 32'h2800_1100,
    32'h2800_1180, 32'h2800_1000, 32'h5800_0241, 32'h6800_104f};

  always #5 sys_clk = ~sys_clk;

  // two triggers so that out-of-range selection can be tried
  dtc_trigger_unit #(.TRIGGER_COUNT_PARAM(2)) DUT (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .csr_addr_i(addr),
    .csr_re_i(re), .csr_we_i(we), .csr_wdata_i(wdata),
    .debug_mode_i(debug_mode), .priv_m_i(priv_m),
    .fetch_valid_i(fv), .fetch_addr_i(acc_addr),
    .load_valid_i(lv), .load_addr_i(acc_addr),
    .store_valid_i(sv), .store_addr_i(acc_addr),
    .exc_valid_i(ev), .exc_code_i(acc_addr[4:0]),
    .csr_rdata_o(rdata), .dbg_req_o(dbg_req), .trig_hit_o(hit));

  dtc_dbg_model partner (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .dbg_req_i(dbg_req),
    .halt_i(halt), .resume_i(resume), .debug_mode_o(debug_mode));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge sys_clk);
    we = 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic csr_rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    addr = a;
    re = 1'b1;
    @(negedge sys_clk);
    re = 1'b0;
    check($sformatf("csr %h", a), exp, rdata);
  endtask

  task automatic mode(input logic v);
    @(negedge sys_clk);
    halt = v;
    resume = !v;
    @(negedge sys_clk);
    halt = 1'b0;
    resume = 1'b0;
    @(negedge sys_clk);
    check("debug mode", {31'h0, v}, {31'h0, debug_mode});
  endtask

  // kind 0 fetch, 1 load, 2 store, 3 exception (code from address)
  task automatic access(input logic [1:0] k, input logic [31:0] a,
                        input logic m, input logic [1:0] exp);
    @(negedge sys_clk);
    priv_m = m;
    acc_addr = a;
    fv = (k == 2'd0);
    lv = (k == 2'd1);
    sv = (k == 2'd2);
    ev = (k == 2'd3);
    @(negedge sys_clk);
    {fv, lv, sv, ev} = 4'h0;
    check("trigger hit", {30'h0, exp}, {30'h0, hit});
    check("debug request", {31'h0, |exp}, {31'h0, dbg_req});
    @(negedge sys_clk);
    check("request pulse", 32'h0, {31'h0, dbg_req});
    if (|exp)
      mode(1'b0);
  endtask

  task automatic t_reset_values;
    csr_rd(`DTC_ADDR_TRIG_SEL, `DTC_SEL_RESET);
    csr_rd(`DTC_ADDR_TRIG_CFG, `DTC_CFG_RESET);
    csr_rd(`DTC_ADDR_TRIG_CMP, `DTC_CMP_RESET);
    csr_rd(`DTC_ADDR_TRIG_INFO, `DTC_INFO_VALUE);
    csr_rd(`DTC_ADDR_TRIG_AUX, 32'h0000_0000);
    csr_rd(`DTC_ADDR_TRIG_CTRL, 32'h0000_0000);
    csr_rd(12'h123, 32'h0000_0000);
    access(2'd0, 32'h0000_0000, 1'b1, 2'b00);
  endtask

  // outside debug mode the trigger data registers refuse writes
  task automatic t_select;
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0001);
    csr_rd(`DTC_ADDR_TRIG_SEL, 32'h0000_0001);
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0002);
    csr_rd(`DTC_ADDR_TRIG_SEL, 32'h0000_0001);
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0000);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h0000_0000);
    csr_rd(`DTC_ADDR_TRIG_CFG, `DTC_CFG_RESET);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'h0000_0005);
    csr_rd(`DTC_ADDR_TRIG_CMP, 32'h0000_0000);
  endtask

  task automatic t_legalize;
    mode(1'b1);
    for (int i = 0; i < 10; i++) begin
      csr_wr(`DTC_ADDR_TRIG_CFG, LEG_WR[i]);
      csr_rd(`DTC_ADDR_TRIG_CFG, LEG_RD[i]);
    end
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h5000_0000);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'hffff_ffff);
    csr_rd(`DTC_ADDR_TRIG_CMP, `DTC_EXC_CODE_MASK);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h2000_0000);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'hffff_ffff);
    csr_rd(`DTC_ADDR_TRIG_CMP, 32'hffff_ffff);
  endtask

  // trigger 0: fetch equal in machine mode; trigger 1: below, user
  task automatic t_addr_match;
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h2000_0044);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'h0000_0100);
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0001);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h2000_018b);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'h0000_0200);
    access(2'd0, 32'h0000_0100, 1'b1, 2'b00);
    mode(1'b0);
    access(2'd0, 32'h0000_0100, 1'b1, 2'b01);
    access(2'd0, 32'h0000_0104, 1'b1, 2'b00);
    access(2'd0, 32'h0000_0100, 1'b0, 2'b00);
    access(2'd1, 32'h0000_0100, 1'b1, 2'b00);
    access(2'd1, 32'h0000_01fc, 1'b0, 2'b10);
    access(2'd2, 32'h0000_0200, 1'b0, 2'b00);
    access(2'd2, 32'h0000_00ff, 1'b0, 2'b10);
  endtask

  // trigger 0 on exception code 2, trigger 1 fetch at or above
  task automatic t_exc_match;
    mode(1'b1);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h2000_0144);
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0000);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h5000_0200);
    csr_wr(`DTC_ADDR_TRIG_CMP, 32'h0000_0004);
    mode(1'b0);
    access(2'd3, 32'h0000_0002, 1'b1, 2'b01);
    access(2'd3, 32'h0000_0003, 1'b1, 2'b00);
    access(2'd3, 32'h0000_0002, 1'b0, 2'b00);
    access(2'd0, 32'h0000_0200, 1'b1, 2'b10);
    access(2'd0, 32'h0000_01fc, 1'b1, 2'b00);
    mode(1'b1);
    csr_wr(`DTC_ADDR_TRIG_SEL, 32'h0000_0001);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h0000_0000);
    mode(1'b0);
    access(2'd0, 32'h0000_0200, 1'b1, 2'b00);
    // newer address-match type: load equal in machine mode
    mode(1'b1);
    csr_wr(`DTC_ADDR_TRIG_CFG, 32'h6000_0041);
    mode(1'b0);
    access(2'd1, 32'h0000_0200, 1'b1, 2'b10);
  endtask

  task automatic close_out;
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // guard against a hang anywhere in the sequence
  initial begin
    #200000;
    n_errors++;
    $display("unexpected run length: expected end, seen none");
    close_out();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_reset_values();
    t_select();
    t_legalize();
    t_addr_match();
    t_exc_match();
    close_out();
  end
endmodule
`default_nettype wire
